// ==== core/dtc_top.sv ====
// Two cascadable timer pairs and eight capture channels on AXI4-Lite
`timescale 1ns/10ps
`include "dtc_map.svh"
module dtc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep,
  input wire logic [3:0] timer_pin,
  input wire logic [7:0] cap_pin,
  output logic [3:0] irq_req,
  output logic adc_trigger
);
  logic [15:0] cnt_r [4];
  logic [15:0] cnt_nxt [4];
  logic [15:0] per_r [4];
  logic [15:0] per_nxt [4];
  logic [15:0] ctl_r [4];
  logic [15:0] ctl_nxt [4];
  logic [7:0] psc_r [4];
  logic [7:0] psc_nxt [4];
  logic [15:0] hold_r [2];
  logic [15:0] hold_nxt [2];
  logic [15:0] flag_r;
  logic [15:0] flag_nxt;
  logic [15:0] en_r;
  logic [15:0] en_nxt;
  logic adc_r;
  logic adc_nxt;
  logic [3:0] tick;
  logic [3:0] flag_set;
  logic [2:0] cmode_r [8];
  logic [2:0] cmode_nxt [8];
  logic [3:0] cpsc_r [8];
  logic [3:0] cpsc_nxt [8];
  logic [7:0] ovf_r;
  logic [7:0] ovf_nxt;
  logic [7:0] push;
  logic [7:0] pop;
  logic [15:0] head [8];
  logic [2:0] level [8];
  logic [11:0] pin_s1_r;
  logic [11:0] pin_s2_r;
  logic [11:0] pin_d_r;
  logic [11:0] rise;
  logic [11:0] fall;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic wr_go;
  logic rd_go;
  dtc_pkg::dtc_dec_s wdec;
  dtc_pkg::dtc_dec_s rdec;
  logic [15:0] wval;

  function automatic dtc_pkg::dtc_dec_s decode(input logic [9:0] idx);
    logic [9:0] rel;
    rel = idx - `DTC_CAP_BUF0;
    decode = '{dtc_pkg::K_NONE, 3'h0};
    if (idx == `DTC_A_LOW_COUNT) begin
      decode = '{dtc_pkg::K_CNT, 3'h0};
    end else if (idx == `DTC_A_HIGH_HOLD) begin
      decode = '{dtc_pkg::K_HOLD, 3'h0};
    end else if (idx == `DTC_A_HIGH_COUNT) begin
      decode = '{dtc_pkg::K_CNT, 3'h1};
    end else if (idx == `DTC_A_LOW_PERIOD) begin
      decode = '{dtc_pkg::K_PER, 3'h0};
    end else if (idx == `DTC_A_HIGH_PERIOD) begin
      decode = '{dtc_pkg::K_PER, 3'h1};
    end else if (idx == `DTC_A_LOW_CONTROL) begin
      decode = '{dtc_pkg::K_CTL, 3'h0};
    end else if (idx == `DTC_A_HIGH_CONTROL) begin
      decode = '{dtc_pkg::K_CTL, 3'h1};
    end else if (idx == `DTC_B_LOW_COUNT) begin
      decode = '{dtc_pkg::K_CNT, 3'h2};
    end else if (idx == `DTC_B_HIGH_HOLD) begin
      decode = '{dtc_pkg::K_HOLD, 3'h1};
    end else if (idx == `DTC_B_HIGH_COUNT) begin
      decode = '{dtc_pkg::K_CNT, 3'h3};
    end else if (idx == `DTC_B_LOW_PERIOD) begin
      decode = '{dtc_pkg::K_PER, 3'h2};
    end else if (idx == `DTC_B_HIGH_PERIOD) begin
      decode = '{dtc_pkg::K_PER, 3'h3};
    end else if (idx == `DTC_B_LOW_CONTROL) begin
      decode = '{dtc_pkg::K_CTL, 3'h2};
    end else if (idx == `DTC_B_HIGH_CONTROL) begin
      decode = '{dtc_pkg::K_CTL, 3'h3};
    end else if (idx == `DTC_IRQ_FLAG_REG0) begin
      decode = '{dtc_pkg::K_IRQFLAG, 3'h0};
    end else if (idx == `DTC_IRQ_ENABLE_REG0) begin
      decode = '{dtc_pkg::K_IRQEN, 3'h0};
    end else if (idx >= `DTC_CAP_BUF0 && idx < `DTC_CAP_END && !rel[0]) begin
      if (rel[1]) begin
        decode = '{dtc_pkg::K_CAPCTL, rel[4:2]};
      end else begin
        decode = '{dtc_pkg::K_CAPBUF, rel[4:2]};
      end
    end
  endfunction

  function automatic logic [7:0] psc_limit(input logic [1:0] code);
    case (code)
      2'h0: psc_limit = `DTC_PSC_LIM1;
      2'h1: psc_limit = `DTC_PSC_LIM8;
      2'h2: psc_limit = `DTC_PSC_LIM64;
      default: psc_limit = `DTC_PSC_LIM256;
    endcase
  endfunction

  // Pins are asynchronous: two flops, then a third for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 12'h000;
      pin_s2_r <= 12'h000;
      pin_d_r <= 12'h000;
    end else begin
      pin_s1_r <= {cap_pin, timer_pin};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  assign rise = pin_s2_r & ~pin_d_r;
  assign fall = ~pin_s2_r & pin_d_r;

  // Bus handshake: write address and data are taken together
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !rvalid_r;
  assign wr_go = s_axi_awready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wdec = decode(s_axi_awaddr[11:2]);
  assign rdec = decode(s_axi_araddr[11:2]);
  assign wval = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00,
                 s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};

  // Timer group
  always_comb begin
    logic casc;
    logic ev;
    logic [1:0] u;
    int lo;
    int hi;
    casc = 1'b0;
    ev = 1'b0;
    u = 2'h0;
    lo = 0;
    hi = 0;
    hold_nxt = hold_r;
    en_nxt = en_r;
    adc_nxt = 1'b0;
    flag_set = 4'h0;
    tick = 4'h0;
    for (int t = 0; t < 4; t++) begin
      cnt_nxt[t] = cnt_r[t];
      per_nxt[t] = per_r[t];
      ctl_nxt[t] = ctl_r[t];
      psc_nxt[t] = psc_r[t];
      casc = ctl_r[t & 2][`DTC_CTL_CASC] && (t % 2 == 1);
      // Internal clock is gone in sleep, so nothing advances
      ev = ctl_r[t][`DTC_CTL_ON] && !sleep && !casc &&
           (ctl_r[t][`DTC_CTL_SRC] ? rise[t] :
            (ctl_r[t][`DTC_CTL_GATE] ? pin_s2_r[t] : 1'b1));
      if (ev) begin
        if (psc_r[t] == psc_limit(ctl_r[t][`DTC_CTL_PS_HI:`DTC_CTL_PS_LO]))
        begin
          psc_nxt[t] = 8'h00;
          tick[t] = 1'b1;
        end else begin
          psc_nxt[t] = psc_r[t] + 8'h01;
        end
      end
      if (ctl_r[t][`DTC_CTL_ON] && !sleep && !casc &&
          ctl_r[t][`DTC_CTL_GATE] && !ctl_r[t][`DTC_CTL_SRC] && fall[t])
      begin
        flag_set[t | (ctl_r[t & 2][`DTC_CTL_CASC] ? 1 : 0)] = 1'b1;
      end
    end
    for (int p = 0; p < 2; p++) begin
      lo = 2 * p;
      hi = 2 * p + 1;
      if (ctl_r[lo][`DTC_CTL_CASC]) begin
        if (tick[lo]) begin
          // Low timer is the low word, high timer the high word
          if ({cnt_r[hi], cnt_r[lo]} == {per_r[hi], per_r[lo]}) begin
            cnt_nxt[hi] = 16'h0000;
            cnt_nxt[lo] = 16'h0000;
            flag_set[hi] = 1'b1;
            adc_nxt = adc_nxt || (p == 0);
          end else begin
            {cnt_nxt[hi], cnt_nxt[lo]} = {cnt_r[hi], cnt_r[lo]} + 32'h1;
          end
        end
      end else begin
        for (int t = lo; t <= hi; t++) begin
          if (tick[t]) begin
            if (cnt_r[t] == per_r[t]) begin
              cnt_nxt[t] = 16'h0000;
              flag_set[t] = 1'b1;
              adc_nxt = adc_nxt || (t == 1);
            end else begin
              cnt_nxt[t] = cnt_r[t] + 16'h0001;
            end
          end
        end
      end
    end
    if (rd_go && rdec.kind == dtc_pkg::K_CNT && !rdec.unit[0]) begin
      hold_nxt[rdec.unit[1]] = cnt_r[{rdec.unit[1], 1'b1}];
    end
    u = wdec.unit[1:0];
    if (wr_go) begin
      case (wdec.kind)
        dtc_pkg::K_CNT: begin
          cnt_nxt[u] = wval;
          psc_nxt[u] = 8'h00;
          if (!u[0] && ctl_r[u][`DTC_CTL_CASC]) begin
            cnt_nxt[u | 2'h1] = hold_r[u[1]];
          end
        end
        dtc_pkg::K_HOLD: hold_nxt[wdec.unit[0]] = wval;
        dtc_pkg::K_PER: per_nxt[u] = wval;
        dtc_pkg::K_CTL: begin
          ctl_nxt[u] = wval & (u[0] ? `DTC_CTL_WMASK_HI : `DTC_CTL_WMASK_LO);
          psc_nxt[u] = 8'h00;
        end
        dtc_pkg::K_IRQEN: en_nxt = wval & `DTC_IRQ_MASK;
        default: ;
      endcase
    end
    // A hardware event in the clearing cycle is kept
    flag_nxt = (wr_go && wdec.kind == dtc_pkg::K_IRQFLAG) ?
               (wval & `DTC_IRQ_MASK) : flag_r;
    flag_nxt = flag_nxt | ({6'h00, flag_set, 6'h00});
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int t = 0; t < 4; t++) begin
        cnt_r[t] <= `DTC_CNT_RESET;
        per_r[t] <= `DTC_PER_RESET;
        ctl_r[t] <= `DTC_CTL_RESET;
        psc_r[t] <= 8'h00;
      end
      hold_r[0] <= `DTC_CNT_RESET;
      hold_r[1] <= `DTC_CNT_RESET;
      flag_r <= 16'h0000;
      en_r <= 16'h0000;
      adc_r <= 1'b0;
    end else begin
      for (int t = 0; t < 4; t++) begin
        cnt_r[t] <= cnt_nxt[t];
        per_r[t] <= per_nxt[t];
        ctl_r[t] <= ctl_nxt[t];
        psc_r[t] <= psc_nxt[t];
      end
      hold_r <= hold_nxt;
      flag_r <= flag_nxt;
      en_r <= en_nxt;
      adc_r <= adc_nxt;
    end
  end

  assign irq_req = flag_r[`DTC_IRQ_BIT0 +: 4] & en_r[`DTC_IRQ_BIT0 +: 4];
  assign adc_trigger = adc_r;

  // Capture group
  always_comb begin
    logic trig;
    logic r;
    logic f;
    logic full;
    logic ne;
    trig = 1'b0;
    r = 1'b0;
    f = 1'b0;
    full = 1'b0;
    ne = 1'b0;
    for (int c = 0; c < 8; c++) begin
      r = rise[4 + c];
      f = fall[4 + c];
      full = level[c] == `DTC_CAP_FULL;
      ne = level[c] != 3'h0;
      cmode_nxt[c] = cmode_r[c];
      cpsc_nxt[c] = cpsc_r[c];
      ovf_nxt[c] = ovf_r[c];
      case (cmode_r[c])
        `DTC_CAP_ANY_EDGE: trig = r || f;
        `DTC_CAP_FALL: trig = f;
        `DTC_CAP_RISE: trig = r;
        `DTC_CAP_RISE4: trig = r && cpsc_r[c] == `DTC_CAP_LIM4;
        `DTC_CAP_RISE16: trig = r && cpsc_r[c] == `DTC_CAP_LIM16;
        default: trig = 1'b0;
      endcase
      if (cmode_r[c] == `DTC_CAP_OFF) begin
        cpsc_nxt[c] = 4'h0;
      end else if (r && (cmode_r[c] == `DTC_CAP_RISE4 ||
                         cmode_r[c] == `DTC_CAP_RISE16)) begin
        cpsc_nxt[c] = trig ? 4'h0 : cpsc_r[c] + 4'h1;
      end
      // Blocked after overflow until every stored word is gone
      push[c] = trig && !full && !(ovf_r[c] && ne);
      pop[c] = rd_go && rdec.kind == dtc_pkg::K_CAPBUF &&
               rdec.unit == c[2:0] && ne;
      if (wr_go && wdec.kind == dtc_pkg::K_CAPCTL && wdec.unit == c[2:0])
      begin
        cmode_nxt[c] = wval[2:0];
        ovf_nxt[c] = wval[`DTC_CAP_OV_BIT] && ovf_r[c];
      end
      // Any-edge mode never reports overflow
      if (trig && full && cmode_r[c] != `DTC_CAP_ANY_EDGE) begin
        ovf_nxt[c] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < 8; c++) begin
        cmode_r[c] <= `DTC_CAP_OFF;
        cpsc_r[c] <= 4'h0;
      end
      ovf_r <= 8'h00;
    end else begin
      cmode_r <= cmode_nxt;
      cpsc_r <= cpsc_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // Time base is always a first-pair timer
  for (genvar c = 0; c < 8; c++) begin : g_cap
    dtc_cap_fifo u_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .push(push[c]),
      .push_data(cnt_r[1]),
      .pop(pop[c]),
      .head_data(head[c]),
      .level(level[c])
    );
  end

  // Bus response group
  always_comb begin
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = wdec.kind == dtc_pkg::K_NONE ? `DTC_RESP_SLVERR
                                               : `DTC_RESP_OKAY;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `DTC_RESP_OKAY;
      case (rdec.kind)
        dtc_pkg::K_CNT: rdata_nxt = {16'h0000, cnt_r[rdec.unit[1:0]]};
        dtc_pkg::K_HOLD: rdata_nxt = {16'h0000, hold_r[rdec.unit[0]]};
        dtc_pkg::K_PER: rdata_nxt = {16'h0000, per_r[rdec.unit[1:0]]};
        dtc_pkg::K_CTL: rdata_nxt = {16'h0000, ctl_r[rdec.unit[1:0]]};
        dtc_pkg::K_CAPBUF: rdata_nxt = {16'h0000, head[rdec.unit]};
        dtc_pkg::K_CAPCTL: rdata_nxt = {27'h0, ovf_r[rdec.unit],
          level[rdec.unit] != 3'h0, cmode_r[rdec.unit]};
        dtc_pkg::K_IRQFLAG: rdata_nxt = {16'h0000, flag_r};
        dtc_pkg::K_IRQEN: rdata_nxt = {16'h0000, en_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = `DTC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `DTC_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `DTC_RESP_OKAY;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule // dtc_top

// ==== core/dtc_map.svh ====
// Register indices, field positions, reset values and counts of the timers
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// Register indices; the byte address is four times the index
`define DTC_A_LOW_COUNT 10'h106
`define DTC_A_HIGH_HOLD 10'h108
`define DTC_A_HIGH_COUNT 10'h10a
`define DTC_A_LOW_PERIOD 10'h10c
`define DTC_A_HIGH_PERIOD 10'h10e
`define DTC_A_LOW_CONTROL 10'h110
`define DTC_A_HIGH_CONTROL 10'h112
`define DTC_B_LOW_COUNT 10'h114
`define DTC_B_HIGH_HOLD 10'h116
`define DTC_B_HIGH_COUNT 10'h118
`define DTC_B_LOW_PERIOD 10'h11a
`define DTC_B_HIGH_PERIOD 10'h11c
`define DTC_B_LOW_CONTROL 10'h11e
`define DTC_B_HIGH_CONTROL 10'h120
`define DTC_IRQ_FLAG_REG0 10'h084
`define DTC_IRQ_ENABLE_REG0 10'h08c
`define DTC_CAP_BUF0 10'h140
`define DTC_CAP_END 10'h160

// Timer control fields
`define DTC_CTL_ON 15
`define DTC_CTL_IDLE 13
`define DTC_CTL_GATE 6
`define DTC_CTL_PS_HI 5
`define DTC_CTL_PS_LO 4
`define DTC_CTL_CASC 3
`define DTC_CTL_SRC 1
`define DTC_CTL_WMASK_LO 16'ha07a
`define DTC_CTL_WMASK_HI 16'ha072
`define DTC_CTL_RESET 16'h0000
`define DTC_PER_RESET 16'hffff
`define DTC_CNT_RESET 16'h0000

// Prescaler terminal counts for 1, 8, 64 and 256
`define DTC_PSC_LIM1 8'h00
`define DTC_PSC_LIM8 8'h07
`define DTC_PSC_LIM64 8'h3f
`define DTC_PSC_LIM256 8'hff

// Interrupt flag and enable bits, bit of timer t is BIT0 + t
`define DTC_IRQ_BIT0 6
`define DTC_IRQ_MASK 16'h03c0

// Capture control fields and modes
`define DTC_CAP_NE_BIT 3
`define DTC_CAP_OV_BIT 4
`define DTC_CAP_OFF 3'h0
`define DTC_CAP_ANY_EDGE 3'h1
`define DTC_CAP_FALL 3'h2
`define DTC_CAP_RISE 3'h3
`define DTC_CAP_RISE4 3'h4
`define DTC_CAP_RISE16 3'h5
`define DTC_CAP_LIM4 4'h3
`define DTC_CAP_LIM16 4'hf
`define DTC_CAP_DEPTH 4
`define DTC_CAP_FULL 3'h4

// Bus responses
`define DTC_RESP_OKAY 2'h0
`define DTC_RESP_SLVERR 2'h2

`endif

// ==== core/dtc_pkg.sv ====
// Types shared by the timer and capture block
package dtc_pkg;

  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_CNT = 4'h1,
    K_HOLD = 4'h2,
    K_PER = 4'h3,
    K_CTL = 4'h4,
    K_CAPBUF = 4'h5,
    K_CAPCTL = 4'h6,
    K_IRQFLAG = 4'h7,
    K_IRQEN = 4'h8
  } dtc_kind_e;

  typedef struct packed {
    dtc_kind_e kind;
    logic [2:0] unit;
  } dtc_dec_s;

endpackage

// ==== core/dtc_cap_fifo.sv ====
// Four-word capture store that shifts forward on every read that finds it not empty
`timescale 1ns/10ps
`include "dtc_map.svh"
module dtc_cap_fifo (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [15:0] push_data,
  input wire logic pop,
  output logic [15:0] head_data,
  output logic [2:0] level
);
  logic [15:0] mem_r [`DTC_CAP_DEPTH];
  logic [15:0] mem_nxt [`DTC_CAP_DEPTH];
  logic [2:0] lvl_r;
  logic [2:0] lvl_nxt;
  logic do_pop;
  logic do_push;
  logic [2:0] wpos;

  always_comb begin
    do_pop = pop && (lvl_r != 3'h0);
    do_push = push && (lvl_r != `DTC_CAP_FULL);
    wpos = do_pop ? lvl_r - 3'h1 : lvl_r;
    for (int i = 0; i < `DTC_CAP_DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (do_pop) begin
      for (int i = 0; i < `DTC_CAP_DEPTH - 1; i++) begin
        mem_nxt[i] = mem_r[i + 1];
      end
    end
    if (do_push) begin
      mem_nxt[wpos[1:0]] = push_data;
    end
    lvl_nxt = lvl_r + {2'h0, do_push} - {2'h0, do_pop};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_r <= 3'h0;
      for (int i = 0; i < `DTC_CAP_DEPTH; i++) begin
        mem_r[i] <= 16'h0000;
      end
    end else begin
      lvl_r <= lvl_nxt;
      for (int i = 0; i < `DTC_CAP_DEPTH; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

  assign head_data = mem_r[0];
  assign level = lvl_r;
endmodule // dtc_cap_fifo

// ==== sim/dtc_pins_model.sv ====
// Pin-side model: timer gate or clock pins and capture inputs
`timescale 1ns/10ps
module dtc_pins_model (
  input wire logic aclk,
  output logic [3:0] timer_pin,
  output logic [7:0] cap_pin
);
  initial begin
    timer_pin = 4'h0;
    cap_pin = 8'h00;
  end
  // Four cycles each side, so the pin synchroniser cannot miss a level
  task automatic pulses(input logic [11:0] m, input int n);
    repeat (n) begin
      @(posedge aclk);
      {cap_pin, timer_pin} <= m;
      repeat (4) @(posedge aclk);
      {cap_pin, timer_pin} <= 12'h000;
      repeat (4) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
  endtask
endmodule // dtc_pins_model

// ==== sim/dtc_top_chk.sv ====
// Bus handshake and sleep checks on the timer block ports
`timescale 1ns/10ps
module dtc_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep,
  input wire logic adc_trigger
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_ready_a: assert property (s_axi_awready ==
    (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("write ready wrong");
  wr_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("write readies differ");
  wr_resp_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("no write response");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_resp_a: assert property (rd_take |=> s_axi_rvalid ##0 s_axi_rdata[31:16]
    == 16'h0000)
    else $error("read response wrong");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_idle_a: assert property (!s_axi_rvalid && !s_axi_arvalid |=>
    !s_axi_rvalid && s_axi_arready)
    else $error("read answer without request");
  sleep_adc_a: assert property (sleep [*3] |-> !adc_trigger)
    else $error("trigger during sleep");
endmodule // dtc_top_chk
bind dtc_top dtc_top_chk u_dtc_top_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sleep(sleep), .adc_trigger(adc_trigger)
);

// ==== sim/dtc_top_bench.sv ====
// Register-level tests of the timer and capture block
`timescale 1ns/10ps
`include "dtc_map.svh"
module dtc_top_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep;
  logic awready, wready, bvalid, arready, rvalid, adc_trigger;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, timer_pin, irq_req;
  logic [7:0] cap_pin;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] v, v2;
  logic [9:0] rst_ix [8] = '{`DTC_A_LOW_PERIOD, `DTC_A_HIGH_PERIOD,
    `DTC_B_LOW_PERIOD, `DTC_B_HIGH_PERIOD, `DTC_A_LOW_CONTROL,
    `DTC_A_HIGH_CONTROL, `DTC_B_LOW_CONTROL, `DTC_B_HIGH_CONTROL};
  int psx [4] = '{256, 256, 32, 8};
  int npl [5] = '{2, 3, 3, 8, 16};
  int nexp [5] = '{4, 3, 3, 2, 1};
  int failures, check_count, adcs, n;

  dtc_top u_dtc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep(sleep), .timer_pin(timer_pin),
    .cap_pin(cap_pin), .irq_req(irq_req), .adc_trigger(adc_trigger)
  );
  dtc_pins_model u_dtc_pins_model (
    .aclk(aclk), .timer_pin(timer_pin), .cap_pin(cap_pin)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) if (adc_trigger === 1'b1) adcs++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] ix, input logic [15:0] d);
    @(posedge aclk);
    awaddr <= {ix, 2'h0};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input logic [9:0] ix, output logic [15:0] d);
    @(posedge aclk);
    araddr <= {ix, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata[15:0];
    resp = rresp;
  endtask
  task automatic rc(input logic [9:0] ix, input logic [15:0] e);
    logic [15:0] d;
    rd(ix, d);
    chk(32'(d), 32'(e));
  endtask
  // Pops only while the not-empty flag is up
  task automatic drain(input int ch, output int k);
    logic [15:0] d;
    k = 0;
    repeat (5) begin
      rd(10'(`DTC_CAP_BUF0 + 4 * ch + 2), d);
      if (d[`DTC_CAP_NE_BIT] === 1'b1) begin
        rd(10'(`DTC_CAP_BUF0 + 4 * ch), d);
        k++;
      end
    end
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    results();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, sleep} = 6'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rst_ix[i]) rc(rst_ix[i], i < 4 ? 16'hffff : 16'h0000);
    rd(10'h000, v);
    chk(32'(resp), 32'(`DTC_RESP_SLVERR));
    wr(10'h3ff, 16'h1234);
    chk(32'(resp), 32'(`DTC_RESP_SLVERR));
    $display("end of reset test");
    wr(`DTC_A_LOW_PERIOD, 16'h0003);
    wr(`DTC_A_HIGH_PERIOD, 16'h0000);
    wr(`DTC_A_LOW_CONTROL, 16'h8008);
    repeat (20) @(posedge aclk);
    rd(`DTC_A_LOW_COUNT, v);
    chk(32'(v < 16'h0004), 32'h1);
    rc(`DTC_A_HIGH_HOLD, 16'h0000);
    rc(`DTC_IRQ_FLAG_REG0, 16'h0080);
    chk(32'(irq_req), 32'h0);
    wr(`DTC_IRQ_ENABLE_REG0, 16'h0080);
    chk(32'(irq_req), 32'h2);
    wr(`DTC_A_LOW_CONTROL, 16'h0000);
    wr(`DTC_IRQ_FLAG_REG0, 16'h0000);
    chk(32'(irq_req), 32'h0);
    wr(`DTC_A_LOW_PERIOD, 16'hffff);
    wr(`DTC_A_LOW_CONTROL, 16'h8048);
    u_dtc_pins_model.pulses(12'h001, 1);
    chk(32'(irq_req), 32'h2);
    wr(`DTC_A_LOW_CONTROL, 16'h0000);
    wr(`DTC_IRQ_FLAG_REG0, 16'h0000);
    $display("end of cascade test");
    wr(`DTC_B_LOW_CONTROL, 16'h0008);
    wr(`DTC_B_HIGH_HOLD, 16'h1234);
    wr(`DTC_B_LOW_COUNT, 16'h0005);
    rc(`DTC_B_HIGH_COUNT, 16'h1234);
    wr(`DTC_B_HIGH_HOLD, 16'h0abc);
    wr(`DTC_B_HIGH_CONTROL, 16'h8000);
    rc(`DTC_B_LOW_COUNT, 16'h0005);
    rc(`DTC_B_HIGH_HOLD, 16'h1234);
    rc(`DTC_B_HIGH_COUNT, 16'h1234);
    wr(`DTC_B_HIGH_CONTROL, 16'h0000);
    $display("end of holding test");
    adcs = 0;
    for (int p = 0; p < 4; p++) begin
      wr(`DTC_B_LOW_CONTROL, 16'h0000);
      wr(`DTC_B_LOW_COUNT, 16'h0000);
      wr(`DTC_B_LOW_CONTROL, 16'h8000 | 16'(p << 4));
      repeat (2050) @(posedge aclk);
      wr(`DTC_B_LOW_CONTROL, 16'h0000);
      rd(`DTC_B_LOW_COUNT, v);
      chk(32'(p == 0 ? v >> 3 : v), 32'(psx[p]));
    end
    wr(`DTC_B_LOW_CONTROL, 16'h8000);
    sleep <= 1'b1;
    rd(`DTC_B_LOW_COUNT, v);
    repeat (50) @(posedge aclk);
    rd(`DTC_B_LOW_COUNT, v2);
    chk(32'(v2), 32'(v));
    sleep <= 1'b0;
    rd(`DTC_B_LOW_COUNT, v2);
    chk(32'(v2 > v), 32'h1);
    wr(`DTC_B_LOW_CONTROL, 16'h0000);
    wr(`DTC_B_HIGH_PERIOD, 16'h0002);
    wr(`DTC_B_HIGH_CONTROL, 16'h8000);
    repeat (50) @(posedge aclk);
    chk(32'(adcs), 32'h0);
    wr(`DTC_B_HIGH_CONTROL, 16'h0000);
    wr(`DTC_A_HIGH_PERIOD, 16'h0002);
    wr(`DTC_A_HIGH_CONTROL, 16'h8000);
    repeat (50) @(posedge aclk);
    wr(`DTC_A_HIGH_CONTROL, 16'h0000);
    chk(32'(adcs > 0), 32'h1);
    $display("end of prescale test");
    wr(10'h15e, 16'h0003);
    for (int k = 0; k < 5; k++) begin
      wr(`DTC_A_HIGH_COUNT, 16'h0100 + 16'(k));
      u_dtc_pins_model.pulses(12'h800, 1);
    end
    rc(10'h15e, 16'h001b);
    rc(10'h15c, 16'h0100);
    wr(`DTC_A_HIGH_COUNT, 16'h0105);
    u_dtc_pins_model.pulses(12'h800, 1);
    for (int k = 1; k < 4; k++)
      rc(10'h15c, 16'h0100 + 16'(k));
    rc(10'h15e, 16'h0013);
    for (int m = 1; m < 6; m++) begin
      wr(10'(`DTC_CAP_BUF0 + 4 * m - 2), 16'(m));
      u_dtc_pins_model.pulses(12'h008 << m, npl[m - 1]);
      drain(m - 1, n);
      chk(32'(n), 32'(nexp[m - 1]));
    end
    wr(10'h156, 16'h0004);
    u_dtc_pins_model.pulses(12'h200, 3);
    wr(10'h156, 16'h0000);
    wr(10'h156, 16'h0004);
    u_dtc_pins_model.pulses(12'h200, 1);
    drain(5, n);
    chk(32'(n), 32'h0);
    $display("end of capture test");
    results();
  end
endmodule // dtc_top_bench
